//--- sram_host.sv
// Host controller driving an asynchronous 16-bit static memory through its pins
// Rules of the memory that this block works to
// (RL1) Select only when low select is low and high select is high.
// (RL2) Write happens during overlap of write strobe, select, and byte strobe.
// (RL3) All strobes active to start; any one going inactive ends the write.
// (RL4) Data held stable around the strobe edge that ends the write.
// (RL5) Write strobe stays high through every read cycle.
// (RL6) Address valid no later than select going active.
// (RL7) Address-driven reads: memory updates data after each address change.
// (RL8) Memory floats data when deselected, output disabled, or no byte strobe.
// (RL9) Write pulse with output enable low covers float delay plus setup.
// (RL10) Both byte strobes low in a read returns full word.
// (RL11) Only lower strobe low in a read returns lower byte.
// (RL12) Only upper strobe low in a read returns upper byte.
// (RL13) Both strobes low in a write stores full word.
// (RL14) Lower strobe only writes lower byte, upper untouched.
// (RL15) Upper strobe only writes upper byte, lower untouched.
// (RL16) Host always drives both selects to definite levels.
// (RL17) Selects inactive or both byte strobes high means standby.
// (RL18) Contents persist; reads return last written bytes.
`timescale 1ns/1ps
`default_nettype none
module sram_host #(
    parameter int READ_CYCLES = sram_host_pkg::READ_CYC,
    parameter int WRITE_CYCLES = sram_host_pkg::WRITE_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata_i,
    input wire logic [1:0] req_lanes_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata_o,
    output logic [sram_host_pkg::ADDR_W-1:0] mem_addr_o,
    output logic chip_select_lo_n_o,
    output logic chip_select_hi_o,
    output logic write_strobe_n_o,
    output logic output_enable_n_o,
    output logic upper_byte_strobe_n_o,
    output logic lower_byte_strobe_n_o,
    input wire logic [sram_host_pkg::DATA_W-1:0] mem_data_i,
    output logic [sram_host_pkg::DATA_W-1:0] mem_data_o,
    output logic mem_data_oe_n_o
);
    sram_host_pkg::state_t state;
    sram_host_pkg::state_t next_state;
    logic [sram_host_pkg::CNT_W-1:0] cnt;
    logic [1:0] lanes;
    logic [sram_host_pkg::CNT_W-1:0] read_last;
    logic [sram_host_pkg::CNT_W-1:0] setup_last;
    logic [sram_host_pkg::CNT_W-1:0] strobe_last;
    logic [sram_host_pkg::CNT_W-1:0] write_last;
    logic [sram_host_pkg::CNT_W-1:0] recover_last;
    logic take;
    logic cnt_done;
    logic read_done;
    logic write_active;
    logic next_read;
    logic next_write;
    logic next_access;
    logic [1:0] next_lanes;
    logic [sram_host_pkg::DATA_W-1:0] read_mask;
    logic [sram_host_pkg::DATA_W-1:0] next_rdata;

    // Lane bits are active low, so a cleared bit opens its byte
    function automatic logic [sram_host_pkg::DATA_W-1:0] lane_mask(input logic [1:0] l);
        return {{sram_host_pkg::BYTE_W{~l[1]}}, {sram_host_pkg::BYTE_W{~l[0]}}};
    endfunction

    function automatic logic in_access(input sram_host_pkg::state_t s);
        return (s == sram_host_pkg::st_read) || (s == sram_host_pkg::st_write);
    endfunction

    assign read_last = sram_host_pkg::CNT_W'(READ_CYCLES - 1);
    // Strobe window sits one count early, as the pin follows it a cycle late
    assign setup_last = sram_host_pkg::CNT_W'(sram_host_pkg::SETUP_CYC - 1);
    assign strobe_last = sram_host_pkg::CNT_W'(sram_host_pkg::SETUP_CYC + WRITE_CYCLES - 1);
    // One spare cycle after the strobe rises keeps select and data past the write end
    assign write_last = sram_host_pkg::CNT_W'(sram_host_pkg::SETUP_CYC + WRITE_CYCLES);
    assign recover_last = sram_host_pkg::CNT_W'(sram_host_pkg::RECOVER_CYC - 1);
    // Empty lane mask would be standby, so such a request is refused
    assign take = (state == sram_host_pkg::st_idle) && req_ready_o && req_valid_i
        && (req_lanes_i != sram_host_pkg::LANES_NONE);
    assign cnt_done = (state == sram_host_pkg::st_read) ? (cnt == read_last)
        : (state == sram_host_pkg::st_write) ? (cnt == write_last)
        : (cnt == recover_last);
    assign read_done = (state == sram_host_pkg::st_read) && cnt_done;
    // Write strobe low only after address has settled under select
    assign write_active = (state == sram_host_pkg::st_write) && (cnt >= setup_last)
        && (cnt < strobe_last); // RL3
    assign next_read = (next_state == sram_host_pkg::st_read);
    assign next_write = (next_state == sram_host_pkg::st_write);
    assign next_access = in_access(next_state);
    assign next_lanes = !next_access ? sram_host_pkg::LANES_NONE
        : (take ? req_lanes_i : lanes);
    // Undriven lanes read back as zero
    assign read_mask = lane_mask(lanes); // RL11 RL12
    assign next_rdata = mem_data_i & read_mask; // RL10

    always_comb
    begin
        next_state = state;
        unique case (state)
            sram_host_pkg::st_idle:
                if (take)
                    next_state = req_write_i ? sram_host_pkg::st_write : sram_host_pkg::st_read;
            sram_host_pkg::st_read, sram_host_pkg::st_write:
                if (cnt_done)
                    next_state = sram_host_pkg::st_recover;
            sram_host_pkg::st_recover:
                if (cnt_done)
                    next_state = sram_host_pkg::st_idle;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            state <= sram_host_pkg::st_idle;
            cnt <= '0;
            lanes <= sram_host_pkg::LANES_NONE;
        end
        else
        begin
            state <= next_state;
            cnt <= (next_state != state) ? '0 : cnt + 1'b1;
            if (take)
                lanes <= req_lanes_i;
        end
    end

    // Address and data latch together with select, on the same edge as it
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            mem_addr_o <= '0;
            mem_data_o <= '0;
        end
        else if (take)
        begin
            mem_addr_o <= req_addr_i; // RL6
            mem_data_o <= req_wdata_i; // RL4
        end
    end

    // Both selects always driven to a level; standby keeps them inactive
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            chip_select_lo_n_o <= 1'b1; // RL16 RL17
            chip_select_hi_o <= 1'b0;
        end
        else
        begin
            chip_select_lo_n_o <= !next_access; // RL1
            chip_select_hi_o <= next_access; // RL1
        end
    end

    // Strobe held high on reads; low only mid-write so it ends first
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            write_strobe_n_o <= 1'b1;
            output_enable_n_o <= 1'b1;
        end
        else
        begin
            write_strobe_n_o <= !write_active; // RL2 RL5 RL9
            output_enable_n_o <= !next_read; // RL8
        end
    end

    // An empty mask is never taken, so both strobes high only outside accesses
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            upper_byte_strobe_n_o <= 1'b1;
            lower_byte_strobe_n_o <= 1'b1;
        end
        else
        begin
            upper_byte_strobe_n_o <= next_lanes[1]; // RL13 RL15
            lower_byte_strobe_n_o <= next_lanes[0]; // RL13 RL14
        end
    end

    // Data stays driven until select drops, covering hold
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            mem_data_oe_n_o <= 1'b1;
        else
            mem_data_oe_n_o <= !next_write; // RL4
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
        end
        else
        begin
            rsp_valid_o <= read_done; // RL18
            if (read_done)
                rsp_rdata_o <= next_rdata;
        end
    end

    // Take also needs ready, so a request seen just after reset is not taken early
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            req_ready_o <= 1'b0;
        else
            req_ready_o <= (next_state == sram_host_pkg::st_idle) && !take;
    end
endmodule
`default_nettype wire

//--- sram_host_pkg.sv
// Constants for the asynchronous static memory host controller
package sram_host_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    // Timing in ns for the slower speed grade
    localparam int CLK_PERIOD_NS = 4;
    localparam int READ_CYCLE_NS = 55;
    localparam int ADDR_SETUP_NS = 40;
    localparam int WRITE_PULSE_NS = 40;
    localparam int WRITE_FLOAT_DELAY_NS = 20;
    localparam int WRITE_DATA_SETUP_NS = 25;
    localparam int RECOVER_NS = 20;
    // Least times round up to whole cycles
    function automatic int cycles_up(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction
    localparam int READ_CYC = cycles_up(READ_CYCLE_NS) + 1;
    localparam int FLOAT_SETUP_NS = WRITE_FLOAT_DELAY_NS + WRITE_DATA_SETUP_NS;
    localparam int PULSE_NS = (WRITE_PULSE_NS > FLOAT_SETUP_NS) ? WRITE_PULSE_NS : FLOAT_SETUP_NS;
    localparam int WRITE_CYC = cycles_up(PULSE_NS);
    localparam int SETUP_CYC = cycles_up(ADDR_SETUP_NS);
    localparam int RECOVER_CYC = cycles_up(RECOVER_NS);
    localparam int CNT_W = 8;
    localparam logic [1:0] LANES_NONE = 2'h3;
    typedef enum logic [1:0] {st_idle, st_read, st_write, st_recover} state_t;
endpackage

//--- sram_host_asserts.sv
// Port assertions for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module sram_host_asserts #(
    parameter int READ_CYCLES = 3,
    parameter int WRITE_CYCLES = 3
) (
    input wire logic core_clk_i, rst_i, req_valid_i, req_write_i, req_ready_o, rsp_valid_o,
    input wire logic chip_select_lo_n_o, chip_select_hi_o, write_strobe_n_o, mem_data_oe_n_o,
    input wire logic output_enable_n_o, upper_byte_strobe_n_o, lower_byte_strobe_n_o,
    input wire logic [1:0] req_lanes_i,
    input wire logic [17:0] mem_addr_o,
    input wire logic [15:0] mem_data_o
);
    localparam int RD = READ_CYCLES + 1;
    localparam int RD2 = READ_CYCLES + 2;
    localparam int WR = WRITE_CYCLES;
    wire logic sel = !chip_select_lo_n_o && chip_select_hi_o;
    wire logic lane = !(upper_byte_strobe_n_o && lower_byte_strobe_n_o);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take_rd;
        req_valid_i && req_ready_o && !req_write_i && req_lanes_i != 2'h3;
    endsequence
    sequence s_we_end;
        $rose(write_strobe_n_o);
    endsequence
    a_sel_pair: assert property (chip_select_lo_n_o == !chip_select_hi_o)
        else $error("selects disagree");
    a_we_qual: assert property (!write_strobe_n_o |-> sel && lane && !mem_data_oe_n_o)
        else $error("write strobe without select, lane or data");
    a_we_read: assert property (!output_enable_n_o |-> write_strobe_n_o)
        else $error("write strobe low during read");
    a_addr_hold: assert property (sel && $past(sel) |-> $stable(mem_addr_o))
        else $error("address moved while selected");
    a_data_hold: assert property (s_we_end and $past(!rst_i) |->
        sel && !mem_data_oe_n_o && $stable(mem_data_o))
        else $error("data not held at write end");
    a_we_width: assert property ($fell(write_strobe_n_o) |-> ##WR s_we_end)
        else $error("write pulse width wrong");
    a_read_lat: assert property (s_take_rd |-> ##[RD:RD2] rsp_valid_o)
        else $error("read answer late");
    a_rsp_once: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("answer longer than one cycle");
    a_idle_pins: assert property (req_ready_o |->
        chip_select_lo_n_o && write_strobe_n_o && mem_data_oe_n_o)
        else $error("pins active while idle");
endmodule
bind sram_host sram_host_asserts #(.READ_CYCLES(READ_CYCLES), .WRITE_CYCLES(WRITE_CYCLES))
    sram_host_asserts_inst (.*);
`default_nettype wire

//--- sram_model.sv
// Behavioural model of the byte-lane static memory
`timescale 1ns/1ps
`default_nettype none
module sram_model (
    input wire logic core_clk_i,
    input wire logic [17:0] addr_i,
    input wire logic cs_lo_n_i, cs_hi_i, we_n_i, oe_n_i, ub_n_i, lb_n_i, host_oe_n_i,
    input wire logic [15:0] host_data_i,
    output logic [15:0] bus_o
);
    logic [15:0] mem [logic [17:0]];
    logic [15:0] last = 16'h0;
    logic [15:0] word;
    wire logic sel = !cs_lo_n_i && cs_hi_i && !(ub_n_i && lb_n_i);
    wire logic rd = sel && we_n_i && !oe_n_i;
    // Host ends writes by the strobe, so store at its rise
    always @(posedge we_n_i)
    begin
        if (sel && !lb_n_i) mem[addr_i][7:0] = bus_o[7:0];
        if (sel && !ub_n_i) mem[addr_i][15:8] = bus_o[15:8];
    end
    always @*
    begin
        word = mem.exists(addr_i) ? mem[addr_i] : ~last;
        bus_o = ~last;
        if (rd && !lb_n_i) bus_o[7:0] = word[7:0];
        if (rd && !ub_n_i) bus_o[15:8] = word[15:8];
        if (!host_oe_n_i) bus_o = host_data_i;
    end
    // Undriven lanes invert, so stale data never reads as valid
    always @(posedge core_clk_i) last <= bus_o;
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking testbench for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0;
    logic [17:0] req_addr_i = 18'h0, mem_addr_o, a;
    logic [15:0] req_wdata_i = 16'h0, mem_data_i, mem_data_o, rsp_rdata_o, d;
    logic [1:0] req_lanes_i = 2'h0;
    logic req_ready_o, rsp_valid_o, chip_select_lo_n_o, chip_select_hi_o, write_strobe_n_o;
    logic output_enable_n_o, upper_byte_strobe_n_o, lower_byte_strobe_n_o, mem_data_oe_n_o;
    logic [15:0] shadow [logic [17:0]];
    logic [15:0] expq [$];
    int fail_count = 0, check_count = 0, seed = 63;
    always #2 core_clk_i = ~core_clk_i;
    sram_host #(.READ_CYCLES(3), .WRITE_CYCLES(3)) sram_host_inst (.*);
    sram_model sram_model_inst (.core_clk_i(core_clk_i), .addr_i(mem_addr_o),
        .cs_lo_n_i(chip_select_lo_n_o), .cs_hi_i(chip_select_hi_o), .we_n_i(write_strobe_n_o),
        .oe_n_i(output_enable_n_o), .ub_n_i(upper_byte_strobe_n_o), .lb_n_i(lower_byte_strobe_n_o),
        .host_oe_n_i(mem_data_oe_n_o), .host_data_i(mem_data_o), .bus_o(mem_data_i));
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Lanes are active low: bit 0 lower byte, bit 1 upper byte
    task automatic op(input logic w, input logic [17:0] ad, input logic [15:0] dt,
                      input logic [1:0] l);
        int n = 0;
        // One edge between calls, so valid is never lowered and raised in one step
        @(posedge core_clk_i);
        {req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_lanes_i} <= {1'b1, w, ad, dt, l};
        @(posedge core_clk_i);
        // Request stands until an edge samples ready high
        while (req_ready_o !== 1'b1 && n < 100)
        begin
            @(posedge core_clk_i);
            n++;
        end
        if (req_ready_o !== 1'b1) fail_count++;
        req_valid_i <= 1'b0;
        if (w && !l[0]) shadow[ad][7:0] = dt[7:0];
        if (w && !l[1]) shadow[ad][15:8] = dt[15:8];
        if (!w && l != 2'h3) expq.push_back(shadow[ad] & {{8{!l[1]}}, {8{!l[0]}}});
    endtask
    always @(posedge core_clk_i)
        if (rsp_valid_o === 1'b1)
        begin
            if (expq.size() == 0) chk("spare answer", 16'h1, 16'h0);
            else chk("read data", rsp_rdata_o, expq.pop_front());
        end
    initial
    begin
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            a = 18'($random(seed));
            d = 16'($random(seed));
            op(1'b1, a, d, 2'h0);
            for (int l = 0; l < 3; l++) op(1'b0, a, 16'h0, l[1:0]);
            op(1'b1, a, ~d, 2'h1);
            op(1'b1, a, d ^ 16'h5a5a, 2'h2);
            op(1'b0, a, 16'h0, 2'h3);
            op(1'b0, a, 16'h0, 2'h0);
        end
        op(1'b0, a, 16'h0, 2'h3);
        chk("pending reads", 16'(expq.size()), 16'h0);
        results();
    end
    initial
    begin
        #100000;
        fail_count++;
        results();
    end
endmodule
`default_nettype wire
